// *** bench/fcd_flash_ctl_bench.sv ***
// self-checking bench of the flash clock divider block
`timescale 1ns/1ps
`include "fcd_defs.svh"
module fcd_flash_ctl_bench;
	logic        clk = 0, rst_n = 0, wr = 0, rd = 0, wr_from_secure = 0;
	logic        op_req = 1, mem_req = 0, mem_wr = 0, mem_src_unsecured = 0;
	logic [3:0]  addr = 4'h0;
	logic [7:0]  wdata = 8'h00, nonvolatile_options_byte = 8'h00;
	logic [7:0]  mem_rdata_in = 8'h5a, rdata, mem_rdata;
	logic [63:0] key = 64'h8877665544332211;
	logic        op_allowed, flash_timing_tick, mem_wr_en, secure, vector_redirect_en;
	int          mismatches = 0, n_tests = 0, cyc = 0, gap;
	always #12.5 clk = ~clk;
	fcd_flash_ctl fcd_flash_ctl_inst (.clk, .rst_n, .addr, .wdata, .wr, .rd,
		.wr_from_secure, .rdata, .nonvolatile_options_byte,
		.stored_backdoor_key(key), .op_req, .op_allowed, .flash_timing_tick,
		.mem_req, .mem_wr, .mem_src_unsecured, .mem_rdata_in, .mem_wr_en,
		.mem_rdata, .secure, .vector_redirect_en);
	// --------
	// tasks
	// --------
	task chk(string nm, logic [7:0] s, logic [7:0] e);
		n_tests++;
		if (s !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task finish_test();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task do_reset(logic [7:0] nv);
		rst_n <= 0;
		nonvolatile_options_byte <= nv;
		repeat (4) @(posedge clk);
		rst_n <= 1;
		repeat (2) @(posedge clk);
	endtask
	// one idle edge between writes keeps strobe edges clean
	task wr_reg(logic [3:0] a, logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1;
		@(posedge clk);
		wr <= 0;
	endtask
	task rd_chk(string nm, logic [3:0] a, logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1;
		@(posedge clk);
		rd <= 0;
		#1 chk(nm, rdata, e);
	endtask
	task mem_chk(logic w, logic u, logic [7:0] e, logic en);
		@(posedge clk);
		mem_req <= 1;
		mem_wr <= w;
		mem_src_unsecured <= u;
		@(posedge clk);
		mem_req <= 0;
		#1 chk("mrd", mem_rdata, e);
		chk("mwe", mem_wr_en, en);
	endtask
	task key_in(logic [63:0] k, logic s);
		@(posedge clk);
		wr_from_secure <= s;
		wr_reg(`FCD_OFS_KEYCTL, 8'h01);
		for (int i = 0; i < 8; i++) wr_reg(`FCD_OFS_KEYDATA, k[i*8 +: 8]);
		wr_reg(`FCD_OFS_KEYCTL, 8'h00);
		repeat (3) @(posedge clk);
	endtask
	// capped at 250 so a missing tick cannot hang the run
	task tick_gap();
		gap = 0;
		do begin
			@(posedge clk);
			#1 gap++;
		end while (!flash_timing_tick && gap < 250);
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			mismatches++;
			finish_test();
		end
	end
	// --------
	// sequence
	// --------
	initial begin
		do_reset(8'hbf);
		rd_chk("opt", `FCD_OFS_OPTIONS, 8'h83);
		rd_chk("div", `FCD_OFS_CLKDIV, 8'h00);
		chk("op0", op_allowed, 0);
		tick_gap();
		chk("nogap", gap, 250);
		rd_chk("kdat", `FCD_OFS_KEYDATA, 8'h00);
		rd_chk("kctl", `FCD_OFS_KEYCTL, 8'h00);
		wr_reg(`FCD_OFS_OPTIONS, 8'h00);
		rd_chk("optro", `FCD_OFS_OPTIONS, 8'h83);
		// 40 MHz / (8 * 30) gives about 167 kHz
		wr_reg(`FCD_OFS_CLKDIV, 8'h5d);
		rd_chk("div1", `FCD_OFS_CLKDIV, 8'hdd);
		wr_reg(`FCD_OFS_CLKDIV, 8'h05);
		rd_chk("div2", `FCD_OFS_CLKDIV, 8'hdd);
		chk("op1", op_allowed, 1);
		tick_gap();
		tick_gap();
		chk("gap240", gap, 240);
		chk("redir", vector_redirect_en, 1);
		chk("sec", secure, 1);
		mem_chk(0, 1, 8'h00, 0);
		mem_chk(1, 1, 8'h00, 0);
		mem_chk(0, 0, 8'h5a, 0);
		key_in(key, 0);
		chk("dbgkey", secure, 1);
		key_in(key ^ 64'h1, 1);
		chk("badkey", secure, 1);
		key_in(key, 1);
		chk("goodkey", secure, 0);
		rd_chk("stat", `FCD_OFS_STATUS, 8'h02);
		mem_chk(0, 1, 8'h5a, 0);
		do_reset(8'h41);
		rd_chk("opt2", `FCD_OFS_OPTIONS, 8'h41);
		rd_chk("div3", `FCD_OFS_CLKDIV, 8'h00);
		chk("redir2", vector_redirect_en, 0);
		key_in(key, 1);
		chk("keyoff", secure, 1);
		do_reset(8'h02);
		rd_chk("opt3", `FCD_OFS_OPTIONS, 8'h02);
		chk("unsec", secure, 0);
		mem_chk(1, 1, 8'h00, 1);
		// divide-by-one ticks every clock; op_req is dropped, so no operation is requested
		op_req <= 0;
		wr_reg(`FCD_OFS_CLKDIV, 8'h00);
		chk("op2", op_allowed, 0);
		tick_gap();
		tick_gap();
		chk("gap1", gap, 1);
		finish_test();
	end
endmodule

// *** bench/fcd_flash_ctl_properties.sv ***
// port relations of the flash clock divider block
`timescale 1ns/1ps
`include "fcd_defs.svh"
module fcd_chk (
	input wire logic                   clk,
	input wire logic                   rst_n,
	input wire logic [`FCD_ADDR_W-1:0] addr,
	input wire logic                   rd,
	input wire logic [7:0]             rdata,
	input wire logic                   op_req,
	input wire logic                   op_allowed,
	input wire logic                   mem_req,
	input wire logic                   mem_wr,
	input wire logic                   mem_src_unsecured,
	input wire logic [7:0]             mem_rdata_in,
	input wire logic                   mem_wr_en,
	input wire logic [7:0]             mem_rdata,
	input wire logic                   secure,
	input wire logic                   vector_redirect_en
);
	// --------
	// checks
	// --------
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// options copy lands one edge after release, so reads wait for it
	sequence s_opt; $past(rst_n) && rd && addr == `FCD_OFS_OPTIONS; endsequence
	property p_opt_zero; s_opt |=> rdata[5:2] == 4'h0; endproperty
	a_opt_zero: assert property (p_opt_zero) else $error("opt gap");
	property p_op_cause; op_allowed |-> $past(op_req); endproperty
	a_op_cause: assert property (p_op_cause) else $error("op cause");
	property p_op_gate;
		rd && addr == `FCD_OFS_CLKDIV |=> op_allowed == (rdata[7] && $past(op_req));
	endproperty
	a_op_gate: assert property (p_op_gate) else $error("op gate");
	property p_blk;
		mem_req && mem_src_unsecured && secure |=> !mem_wr_en && mem_rdata == 8'h00;
	endproperty
	a_blk: assert property (p_blk) else $error("not blocked");
	property p_pass;
		mem_req && !mem_wr && !(secure && mem_src_unsecured)
		|=> mem_rdata == $past(mem_rdata_in);
	endproperty
	a_pass: assert property (p_pass) else $error("read lost");
	property p_redir; s_opt |=> vector_redirect_en == !rdata[6]; endproperty
	a_redir: assert property (p_redir) else $error("redirect");
	property p_unsec;
		s_opt ##1 rdata[1:0] == `FCD_SEC_UNSECURED |-> !secure;
	endproperty
	a_unsec: assert property (p_unsec) else $error("unsecured");
	property p_keyoff;
		s_opt ##1 !rdata[7] && rdata[1:0] != `FCD_SEC_UNSECURED |-> secure;
	endproperty
	a_keyoff: assert property (p_keyoff) else $error("key off");
endmodule

bind fcd_flash_ctl fcd_chk fcd_chk_inst (.clk, .rst_n, .addr, .rd, .rdata,
	.op_req, .op_allowed, .mem_req, .mem_wr, .mem_src_unsecured,
	.mem_rdata_in, .mem_wr_en, .mem_rdata, .secure, .vector_redirect_en);

// *** hdl/fcd_defs.svh ***
// constants for the flash clock divider and options block
`ifndef FCD_DEFS_SVH
`define FCD_DEFS_SVH
`define FCD_ADDR_W        4
`define FCD_OFS_CLKDIV    4'h0
`define FCD_OFS_OPTIONS   4'h1
`define FCD_OFS_KEYCTL    4'h2
`define FCD_OFS_KEYDATA   4'h3
`define FCD_OFS_STATUS    4'h4
`define FCD_BIT_LOADED    7
`define FCD_BIT_PRESCALE  6
`define FCD_BIT_BACKDOOR_KEY_ENABLE     7
`define FCD_BIT_NORED     6
`define FCD_DIV_W         6
`define FCD_PRE_LAST      3'h7
`define FCD_SEC_UNSECURED 2'h2
`define FCD_OPT_MASK      8'hc3
`define FCD_KEY_LEN       4'h8
`define FCD_ZERO8         8'h00
`endif

// *** hdl/fcd_flash_ctl.sv ***
// flash clock divider, options register and backdoor key compare
`timescale 1ns/1ps
`include "fcd_defs.svh"

//------------------------------------------------------------
// flash clock divider and options
//------------------------------------------------------------
// Operation
// - loaded flag read-only, cleared by reset, set by first write
// - divider bits readable always, take only first write after reset
// - erase and program refused until the loaded flag is set
// - prescale bit selects bus clock or bus clock divided by eight
// - timing clock is selected input divided by divisor plus one
// - each timing pulse is one bus clock wide, one per timing clock period
// - options byte copied from nonvolatile byte on first clock after reset
// - options bits 5 to 2 read as zero
// - options register readable, writes ignored
// - key enable low means key compare never unsecures
// - key writes accepted only from secure code, not debug
// - matching 8-byte key in order unsecures until reset
// - options bit 6 set disables vector redirection
// - only security code 1:0 means unsecured
// - while secure, deny memory accesses from unsecured sources
// - blocked write ignored, blocked read returns zeros
module fcd_flash_ctl (
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire logic [`FCD_ADDR_W-1:0] addr,
	input  wire logic [7:0]             wdata,
	input  wire logic                   wr,
	input  wire logic                   rd,
	input  wire logic                   wr_from_secure,
	output logic      [7:0]             rdata,
	input  wire logic [7:0]             nonvolatile_options_byte,
	input  wire logic [63:0]            stored_backdoor_key,
	input  wire logic                   op_req,
	output logic                        op_allowed,
	output logic                        flash_timing_tick,
	input  wire logic                   mem_req,
	input  wire logic                   mem_wr,
	input  wire logic                   mem_src_unsecured,
	input  wire logic [7:0]             mem_rdata_in,
	output logic                        mem_wr_en,
	output logic      [7:0]             mem_rdata,
	output logic                        secure,
	output logic                        vector_redirect_en
);

//------------------------------------------------------------
// state
//------------------------------------------------------------
	logic                   divisor_loaded_flag_r, divisor_loaded_flag_nxt;
	logic                   prescale_by_eight_r, prescale_by_eight_nxt;
	logic [`FCD_DIV_W-1:0]  divisor_r, divisor_nxt;
	logic [7:0]             flash_options_r, flash_options_nxt;
	logic                   opt_loaded_r, opt_loaded_nxt;
	logic [2:0]             pre_cnt_r, pre_cnt_nxt;
	logic [`FCD_DIV_W-1:0]  div_cnt_r, div_cnt_nxt;
	logic                   tick_r, tick_nxt;
	fcd_pkg::fcd_key_state_t key_st_r, key_st_nxt;
	logic [3:0]             key_idx_r, key_idx_nxt;
	logic                   key_unlocked_r, key_unlocked_nxt;
	logic [7:0]             rdata_r, rdata_nxt;
	logic                   op_allowed_r, op_allowed_nxt;
	logic                   mem_wr_en_r, mem_wr_en_nxt;
	logic [7:0]             mem_rdata_r, mem_rdata_nxt;
	logic                   secure_r, secure_nxt;
	logic                   redir_r, redir_nxt;
	logic                   code_secure;
	logic                   pre_tick;
	logic                   key_wr;
	logic [7:0]             key_byte;

	assign rdata              = rdata_r;
	assign op_allowed         = op_allowed_r;
	assign flash_timing_tick  = tick_r;
	assign mem_wr_en          = mem_wr_en_r;
	assign mem_rdata          = mem_rdata_r;
	assign secure             = secure_r;
	assign vector_redirect_en = redir_r;

//------------------------------------------------------------
// divider register and timing clock
//------------------------------------------------------------
	always_comb begin
		divisor_loaded_flag_nxt = divisor_loaded_flag_r;
		prescale_by_eight_nxt   = prescale_by_eight_r;
		divisor_nxt             = divisor_r;
		if (wr && addr == `FCD_OFS_CLKDIV && !divisor_loaded_flag_r) begin
			divisor_loaded_flag_nxt = 1'b1;
			prescale_by_eight_nxt   = wdata[`FCD_BIT_PRESCALE];
			divisor_nxt             = wdata[`FCD_DIV_W-1:0];
		end
		// prescaler free-runs; bypassed when prescale bit is clear
		pre_cnt_nxt = pre_cnt_r + 3'h1;
		pre_tick    = !prescale_by_eight_r ||
			(pre_cnt_r == `FCD_PRE_LAST);
		div_cnt_nxt = div_cnt_r;
		tick_nxt    = 1'b0;
		if (pre_tick) begin
			if (div_cnt_r >= divisor_r) begin
				div_cnt_nxt = '0;
				tick_nxt    = 1'b1;
			end else begin
				div_cnt_nxt = div_cnt_r + 6'h01;
			end
		end
		// no timing pulses before the divisor is set
		if (!divisor_loaded_flag_r) begin
			tick_nxt    = 1'b0;
			div_cnt_nxt = '0;
		end
		op_allowed_nxt = op_req && divisor_loaded_flag_r;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			divisor_loaded_flag_r <= 1'b0;
			prescale_by_eight_r   <= 1'b0;
			divisor_r             <= '0;
			pre_cnt_r             <= 3'h0;
			div_cnt_r             <= '0;
			tick_r                <= 1'b0;
			op_allowed_r          <= 1'b0;
		end else begin
			divisor_loaded_flag_r <= divisor_loaded_flag_nxt;
			prescale_by_eight_r   <= prescale_by_eight_nxt;
			divisor_r             <= divisor_nxt;
			pre_cnt_r             <= pre_cnt_nxt;
			div_cnt_r             <= div_cnt_nxt;
			tick_r                <= tick_nxt;
			op_allowed_r          <= op_allowed_nxt;
		end
	end

//------------------------------------------------------------
// options copy and backdoor key
//------------------------------------------------------------
	// key bytes compared one per write, first byte in the low lane
	assign key_byte = stored_backdoor_key[key_idx_r[2:0]*8 +: 8];
	assign key_wr   = wr && addr == `FCD_OFS_KEYDATA;

	always_comb begin
		// copy taken on the first clock after reset release
		opt_loaded_nxt    = 1'b1;
		flash_options_nxt = flash_options_r;
		if (!opt_loaded_r)
			flash_options_nxt = nonvolatile_options_byte &
				`FCD_OPT_MASK;
		key_st_nxt       = key_st_r;
		key_idx_nxt      = key_idx_r;
		key_unlocked_nxt = key_unlocked_r;
		unique case (key_st_r)
			fcd_pkg::FCD_KEY_IDLE: begin
				if (wr && addr == `FCD_OFS_KEYCTL && wdata[0] &&
				    wr_from_secure) begin
					key_st_nxt  = fcd_pkg::FCD_KEY_ENTER;
					key_idx_nxt = 4'h0;
				end
			end
			fcd_pkg::FCD_KEY_ENTER, fcd_pkg::FCD_KEY_BAD: begin
				// debug-side writes are simply dropped
				if (key_wr && wr_from_secure && key_idx_r < `FCD_KEY_LEN) begin
					key_idx_nxt = key_idx_r + 4'h1;
					if (wdata != key_byte)
						key_st_nxt = fcd_pkg::FCD_KEY_BAD;
				end
				if (wr && addr == `FCD_OFS_KEYCTL && !wdata[0] &&
				    wr_from_secure) begin
					key_st_nxt = fcd_pkg::FCD_KEY_IDLE;
					if (key_st_r == fcd_pkg::FCD_KEY_ENTER &&
					    key_idx_r == `FCD_KEY_LEN &&
					    flash_options_r[`FCD_BIT_BACKDOOR_KEY_ENABLE])
						key_unlocked_nxt = 1'b1;
				end
			end
			default: key_st_nxt = fcd_pkg::FCD_KEY_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			opt_loaded_r    <= 1'b0;
			flash_options_r <= `FCD_ZERO8;
			key_st_r        <= fcd_pkg::FCD_KEY_IDLE;
			key_idx_r       <= 4'h0;
			key_unlocked_r  <= 1'b0;
		end else begin
			opt_loaded_r    <= opt_loaded_nxt;
			flash_options_r <= flash_options_nxt;
			key_st_r        <= key_st_nxt;
			key_idx_r       <= key_idx_nxt;
			key_unlocked_r  <= key_unlocked_nxt;
		end
	end

//------------------------------------------------------------
// security gate and read port
//------------------------------------------------------------
	// the secure default covers the cycle before the options copy
	assign code_secure = !opt_loaded_r ||
		(flash_options_r[1:0] != `FCD_SEC_UNSECURED);

	always_comb begin
		secure_nxt    = code_secure && !key_unlocked_r;
		redir_nxt     = opt_loaded_r &&
			!flash_options_r[`FCD_BIT_NORED];
		mem_wr_en_nxt = mem_req && mem_wr &&
			!(secure_r && mem_src_unsecured);
		mem_rdata_nxt = (mem_req && !mem_wr &&
			!(secure_r && mem_src_unsecured)) ?
			mem_rdata_in : `FCD_ZERO8;
		rdata_nxt = `FCD_ZERO8;
		if (rd) begin
			unique case (addr)
				`FCD_OFS_CLKDIV: rdata_nxt = {divisor_loaded_flag_r,
					prescale_by_eight_r, divisor_r};
				`FCD_OFS_OPTIONS: rdata_nxt = flash_options_r;
				`FCD_OFS_KEYCTL: rdata_nxt = {7'h00,
					key_st_r != fcd_pkg::FCD_KEY_IDLE};
				`FCD_OFS_STATUS: rdata_nxt = {6'h00, key_unlocked_r,
					secure_r};
				default: rdata_nxt = `FCD_ZERO8;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			secure_r    <= 1'b1;
			redir_r     <= 1'b0;
			mem_wr_en_r <= 1'b0;
			mem_rdata_r <= `FCD_ZERO8;
			rdata_r     <= `FCD_ZERO8;
		end else begin
			secure_r    <= secure_nxt;
			redir_r     <= redir_nxt;
			mem_wr_en_r <= mem_wr_en_nxt;
			mem_rdata_r <= mem_rdata_nxt;
			rdata_r     <= rdata_nxt;
		end
	end

endmodule

// *** hdl/fcd_pkg.sv ***
// types for the flash clock divider and options block
package fcd_pkg;
	typedef enum logic [1:0] {
		FCD_KEY_IDLE  = 2'b00,
		FCD_KEY_ENTER = 2'b01,
		FCD_KEY_BAD   = 2'b10
	} fcd_key_state_t;
endpackage
